// ### verilog/flut_bank.sv
// Fan table entries seven and eight: register access and duty selection
`timescale 1ns/1ps
`default_nettype none
module flut_bank
  import flut_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [7:0] lut_config,
  input wire logic temp_high_res,
  input wire logic duty_high_res,
  input wire logic fast_pwm,
  input wire logic [8:0] remote_temp,
  input wire logic [7:0] table_offset,
  input wire logic [7:0] duty_in,
  output logic [7:0] duty_out,
  output logic [1:0] entry_hit
);
  logic unlocked;
  logic [8:0] temp_compare;
  logic [8:0] offset_half;
  logic [7:0] limit_read_seven;
  logic [7:0] duty_read_seven;
  logic [7:0] duty_value_seven;
  logic exceeded_seven;
  logic [7:0] limit_read_eight;
  logic [7:0] duty_read_eight;
  logic [7:0] duty_value_eight;
  logic exceeded_eight;
  flut_sel_t sel;
  logic [7:0] next_reg_rdata;
  logic next_reg_hit;
  logic [7:0] next_duty_out;
  logic [1:0] next_entry_hit;

  assign unlocked = lut_config[FLUT_LOCK_BIT];

  always_comb begin
    // Reading in half degrees; low resolution drops the half bit
    temp_compare = temp_high_res ? remote_temp : {remote_temp[8:1], 1'b0};
    offset_half = {table_offset, 1'b0};
  end

  flut_entry u_seven (
    .clk(clk),
    .reset(reset),
    .write_limit(reg_write && unlocked && reg_addr == FLUT_ADDR_LIMIT_SEVEN),
    .write_duty(reg_write && unlocked && reg_addr == FLUT_ADDR_DUTY_SEVEN),
    .write_data(reg_wdata),
    .temp_high_res(temp_high_res),
    .duty_high_res(duty_high_res),
    .fast_pwm(fast_pwm),
    .temp_compare(temp_compare),
    .table_offset(offset_half),
    .limit_read(limit_read_seven),
    .duty_read(duty_read_seven),
    .duty_value(duty_value_seven),
    .exceeded(exceeded_seven)
  );

  flut_entry u_eight (
    .clk(clk),
    .reset(reset),
    .write_limit(reg_write && unlocked && reg_addr == FLUT_ADDR_LIMIT_EIGHT),
    .write_duty(reg_write && unlocked && reg_addr == FLUT_ADDR_DUTY_EIGHT),
    .write_data(reg_wdata),
    .temp_high_res(temp_high_res),
    .duty_high_res(duty_high_res),
    .fast_pwm(fast_pwm),
    .temp_compare(temp_compare),
    .table_offset(offset_half),
    .limit_read(limit_read_eight),
    .duty_read(duty_read_eight),
    .duty_value(duty_value_eight),
    .exceeded(exceeded_eight)
  );

  always_comb begin
    // Higher entry wins when both limits are passed
    if (exceeded_eight) begin
      sel = FLUT_SEL_EIGHT;
    end else if (exceeded_seven) begin
      sel = FLUT_SEL_SEVEN;
    end else begin
      sel = FLUT_SEL_NONE;
    end
    unique case (sel)
      FLUT_SEL_EIGHT: next_duty_out = duty_value_eight;
      FLUT_SEL_SEVEN: next_duty_out = duty_value_seven;
      default: next_duty_out = duty_in;
    endcase
    next_entry_hit = {exceeded_eight, exceeded_seven};
    next_reg_hit = 1'b1;
    unique case (reg_addr)
      FLUT_ADDR_LIMIT_SEVEN: next_reg_rdata = limit_read_seven;
      FLUT_ADDR_DUTY_SEVEN: next_reg_rdata = duty_read_seven;
      FLUT_ADDR_LIMIT_EIGHT: next_reg_rdata = limit_read_eight;
      FLUT_ADDR_DUTY_EIGHT: next_reg_rdata = duty_read_eight;
      default: begin
        next_reg_rdata = 8'h00;
        next_reg_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
      duty_out <= 8'h00;
      entry_hit <= 2'b00;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_hit <= next_reg_hit;
      duty_out <= next_duty_out;
      entry_hit <= next_entry_hit;
    end
  end
endmodule
`default_nettype wire

// ### verilog/flut_pkg.sv
// Package with register map, reset values and mode constants for fan table entries seven and eight
// Notes on behaviour
// - In low temperature resolution the top bit of each limit register is ignored and reads back as zero.
// - In high temperature resolution the top bit joins the lower seven bits to form an eight-bit limit, 0 to 127.5 degrees in half steps.
// - In low temperature resolution each limit uses its lower seven bits only, 0 to 127 degrees in whole steps.
// - Above the seventh limit the fan duty is the one at 0x5d, above the eighth limit the one at 0x5f.
// - The comparison uses nine bits of the remote reading in high resolution and eight bits in low resolution.
// - Every limit is taken as non-negative, its sign bit assumed zero.
// - Limits beyond the programmable maximum are reached only through the table temperature offset, which shifts the thresholds.
// - In low duty resolution the upper two bits of each duty register are ignored and read back as zero.
// - In high duty resolution the upper two bits join the lower six bits into an eight-bit duty.
// - The high resolution duty bits act only while the fan output frequency is the 22.5 kHz setting.
// - In low duty resolution only the lower six bits of each duty register form the duty.
package flut_pkg;
  localparam logic [7:0] FLUT_ADDR_LIMIT_SEVEN = 8'h5c;
  localparam logic [7:0] FLUT_ADDR_DUTY_SEVEN = 8'h5d;
  localparam logic [7:0] FLUT_ADDR_LIMIT_EIGHT = 8'h5e;
  localparam logic [7:0] FLUT_ADDR_DUTY_EIGHT = 8'h5f;
  localparam logic [7:0] FLUT_RESET_LIMIT = 8'h7f;
  localparam logic [7:0] FLUT_RESET_DUTY = 8'h3f;
  localparam int FLUT_LOCK_BIT = 5;
  localparam int FLUT_LIMIT_TOP_BIT = 7;
  localparam int FLUT_DUTY_EXT_LSB = 6;
  typedef enum logic [1:0] {
    FLUT_SEL_NONE = 2'b00,
    FLUT_SEL_SEVEN = 2'b01,
    FLUT_SEL_EIGHT = 2'b10
  } flut_sel_t;
endpackage

// ### verilog/flut_entry.sv
// One table entry: limit and duty storage, masking and threshold compare
`timescale 1ns/1ps
`default_nettype none
module flut_entry
  import flut_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic write_limit,
  input wire logic write_duty,
  input wire logic [7:0] write_data,
  input wire logic temp_high_res,
  input wire logic duty_high_res,
  input wire logic fast_pwm,
  input wire logic [8:0] temp_compare,
  input wire logic [8:0] table_offset,
  output logic [7:0] limit_read,
  output logic [7:0] duty_read,
  output logic [7:0] duty_value,
  output logic exceeded
);
  logic [7:0] limit_reg;
  logic [7:0] duty_reg;
  logic [7:0] next_limit_reg;
  logic [7:0] next_duty_reg;
  logic [8:0] limit_half;
  logic [9:0] threshold;

  always_comb begin
    next_limit_reg = write_limit ? write_data : limit_reg;
    next_duty_reg = write_duty ? write_data : duty_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      limit_reg <= FLUT_RESET_LIMIT;
      duty_reg <= FLUT_RESET_DUTY;
    end else begin
      limit_reg <= next_limit_reg;
      duty_reg <= next_duty_reg;
    end
  end

  always_comb begin
    // Limit in half degrees, sign taken as zero
    if (temp_high_res) begin
      limit_half = {limit_reg[6:0], limit_reg[FLUT_LIMIT_TOP_BIT]};
      limit_read = limit_reg;
    end else begin
      limit_half = {limit_reg[6:0], 1'b0};
      limit_read = {1'b0, limit_reg[6:0]};
    end
    threshold = {1'b0, limit_half} + {1'b0, table_offset};
    exceeded = {1'b0, temp_compare} > threshold;
    if (duty_high_res) begin
      duty_read = duty_reg;
    end else begin
      duty_read = {2'b00, duty_reg[5:0]};
    end
    if (duty_high_res && fast_pwm) begin
      duty_value = duty_reg;
    end else begin
      duty_value = {2'b00, duty_reg[5:0]};
    end
  end
endmodule
`default_nettype wire

// ### sim/flut_monitor.sv
// Assertion checker for the fan table entries block
`timescale 1ns/1ps
`default_nettype none
module flut_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic [7:0] lut_config,
  input wire logic temp_high_res,
  input wire logic duty_high_res,
  input wire logic fast_pwm,
  input wire logic [8:0] remote_temp,
  input wire logic [7:0] table_offset,
  input wire logic [7:0] duty_in,
  input wire logic [7:0] duty_out,
  input wire logic [1:0] entry_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_hit; 1 |=> reg_hit == ($past(reg_addr[7:2]) == 6'h17); endproperty
  a_hit: assert property (p_hit) else $error("hit flag wrong");
  property p_unmapped; !reg_hit |-> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_top; !temp_high_res && reg_addr[7:2] == 6'h17 && !reg_addr[0] |=> !reg_rdata[7]; endproperty
  a_top: assert property (p_top) else $error("limit top bit");
  property p_ext; !duty_high_res && reg_addr[7:2] == 6'h17 && reg_addr[0] |=> reg_rdata[7:6] == 2'b00; endproperty
  a_ext: assert property (p_ext) else $error("duty top bits");
  property p_cold; remote_temp == 9'h000 |=> entry_hit == 2'b00; endproperty
  a_cold: assert property (p_cold) else $error("cold hit");
  property p_hot; remote_temp == 9'h1ff && table_offset == 8'h00 |=> entry_hit == 2'b11; endproperty
  a_hot: assert property (p_hot) else $error("hot miss");
  property p_pass; 1 |=> entry_hit != 2'b00 || duty_out == $past(duty_in); endproperty
  a_pass: assert property (p_pass) else $error("pass duty");
  property p_wr; reg_write && lut_config[5] && reg_addr == 8'h5d && duty_high_res ##1
    reg_addr == 8'h5d && duty_high_res |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_wr: assert property (p_wr) else $error("duty readback");
endmodule
bind flut_bank flut_monitor i_flut_monitor (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .lut_config(lut_config),
  .temp_high_res(temp_high_res), .duty_high_res(duty_high_res), .fast_pwm(fast_pwm), .remote_temp(remote_temp),
  .table_offset(table_offset), .duty_in(duty_in), .duty_out(duty_out), .entry_hit(entry_hit));
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the fan table entries block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, reset, reg_write, temp_high_res, duty_high_res, fast_pwm, reg_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lut_config, table_offset, duty_out;
  logic [8:0] remote_temp;
  logic [1:0] entry_hit;
  int num_errors = 0;
  int samples_checked = 0;
  flut_bank i_flut_bank (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .lut_config(lut_config), .temp_high_res(temp_high_res),
    .duty_high_res(duty_high_res), .fast_pwm(fast_pwm), .remote_temp(remote_temp), .table_offset(table_offset),
    .duty_in(8'h11), .duty_out(duty_out), .entry_hit(entry_hit));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 chk(reg_rdata, e);
  endtask
  task automatic fan(input logic [8:0] t, input logic [7:0] o, input logic [1:0] h, input logic [7:0] d);
    @(posedge clk);
    remote_temp <= t;
    table_offset <= o;
    repeat (2) @(posedge clk);
    #1 chk({6'h00, entry_hit}, {6'h00, h});
    chk(duty_out, d);
  endtask
  task automatic t_reset;
    rd(8'h5c, 8'h7f);
    rd(8'h5d, 8'h3f);
    rd(8'h5e, 8'h7f);
    rd(8'h5f, 8'h3f);
    rd(8'h4a, 8'h00);
    chk({7'h00, reg_hit}, 8'h00);
    rd(8'h5f, 8'h3f);
    chk({7'h00, reg_hit}, 8'h01);
    wr(8'h5c, 8'h85);
    rd(8'h5c, 8'h7f);
    $display("reset test done");
  endtask
  task automatic t_regs;
    lut_config <= 8'h20;
    wr(8'h5c, 8'h85);
    rd(8'h5c, 8'h85);
    temp_high_res <= 1'b0;
    rd(8'h5c, 8'h05);
    temp_high_res <= 1'b1;
    wr(8'h5d, 8'hc5);
    rd(8'h5d, 8'hc5);
    duty_high_res <= 1'b0;
    rd(8'h5d, 8'h05);
    duty_high_res <= 1'b1;
    wr(8'h5e, 8'ha0);
    wr(8'h5f, 8'h7a);
    $display("register test done");
  endtask
  task automatic t_fan;
    // Limits in half degrees: seventh 0x0b (5.5), eighth 0x41 (32.5)
    fan(9'h00c, 8'h00, 2'b01, 8'hc5);
    fast_pwm <= 1'b0;
    fan(9'h00c, 8'h00, 2'b01, 8'h05);
    fast_pwm <= 1'b1;
    fan(9'h00b, 8'h00, 2'b00, 8'h11);
    fan(9'h1ff, 8'h00, 2'b11, 8'h7a);
    fan(9'h00c, 8'h01, 2'b00, 8'h11);
    temp_high_res <= 1'b0;
    fan(9'h00b, 8'h00, 2'b00, 8'h11);
    fan(9'h00c, 8'h00, 2'b01, 8'hc5);
    fan(9'h000, 8'h00, 2'b00, 8'h11);
    $display("fan test done");
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {reset, temp_high_res, duty_high_res, fast_pwm} = 4'hf;
    {reg_write, reg_addr, reg_wdata, lut_config, table_offset, remote_temp} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_regs;
    t_fan;
    end_of_test;
  end
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
